// file: hdl/dspm_pkg.sv
// Constants for the decoder/SPI shared pin multiplexer.
// Assumes a single 125 MHz system clock domain.
package dspm_pkg;

  // Pin function select codes
  typedef enum logic [3:0] {
    DSPM_FN_NONE   = 4'h0,
    DSPM_FN_DEC    = 4'h1,
    DSPM_FN_TIMER  = 4'h2,
    DSPM_FN_SPI    = 4'h4,
    DSPM_FN_GPIO   = 4'h8
  } dspm_fn_t;

  // Pin function request encodings on the fn_sel ports
  localparam logic [1:0] FSEL_PRIMARY = 2'h0;
  localparam logic [1:0] FSEL_TIMER   = 2'h1;
  localparam logic [1:0] FSEL_GPIO    = 2'h2;

  // Bit positions within port C pull-up / GPIO registers
  localparam int PC_BIT_IDX  = 2;
  localparam int PC_BIT_HOME = 3;
  localparam int PC_W        = 16;

  // Reset value of the pull-up enable register: all enabled
  localparam logic [15:0] PUR_RESET = 16'hFFFF;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// file: hdl/dspm_sync.sv
// Two-flop synchroniser bank for pad inputs.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
module dspm_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // Two register stages; reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_reg <= '1;
      q_reg    <= '1;
    end
    else
    begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;

endmodule

// file: hdl/dspm_pin_mux.sv
// Pin multiplexer for the decoder index / home pins (timer, SPI, GPIO alternates).
// Assumes pad inputs are asynchronous; peripherals run on i_clk.
`timescale 1ns/1ps
module dspm_pin_mux
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Configuration
  input  wire logic        i_full_variant,
  input  wire logic        i_index_alternate_sel,
  input  wire logic        i_home_alternate_sel,
  input  wire logic [1:0]  i_idx_fn_sel,
  input  wire logic [1:0]  i_home_fn_sel,
  input  wire logic        i_cfg_valid,
  input  wire logic [15:0] i_port_c_pullup_enable_reg,
  // SPI unit
  input  wire logic        i_spi_master,
  input  wire logic        i_spi_slave_out_line,
  output logic             o_spi_slave_select_in,
  output logic             o_spi_mode_fault,
  // Timer B
  input  wire logic        i_tb2_out,
  input  wire logic        i_tb2_oe,
  input  wire logic        i_tb3_out,
  input  wire logic        i_tb3_oe,
  output logic             o_timer_b_ch2_io,
  output logic             o_timer_b_ch3_io,
  // GPIO port C
  input  wire logic        i_port_c_pin2_out,
  input  wire logic        i_port_c_pin2_dir,
  input  wire logic        i_port_c_pin3_out,
  input  wire logic        i_port_c_pin3_dir,
  output logic             o_port_c_pin2,
  output logic             o_port_c_pin3,
  // Decoder
  output logic             o_decoder_index_in,
  output logic             o_decoder_home_in,
  // Pads
  input  wire logic        i_pad_idx,
  input  wire logic        i_pad_home,
  output logic             o_pad_idx,
  output logic             o_pad_idx_oe,
  output logic             o_pad_idx_pu,
  output logic             o_pad_home,
  output logic             o_pad_home_oe,
  output logic             o_pad_home_pu
);

  // ---------------------------------------------------------------
  // Reset release and pad input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rstn_reg;
  logic [1:0] pad_sync;

  // Async assert, synchronous release through two flops
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
  end

  assign rstn_reg = rst_sync_reg[1]; // Only the second flop is read

  // Pad levels cross into the clock domain
  dspm_sync #(.W(2)) u_sync (.i_clk(i_clk), .i_rstn(rstn_reg), .i_d({i_pad_home, i_pad_idx}), .o_q(pad_sync));

  // ---------------------------------------------------------------
  // Function selection
  // ---------------------------------------------------------------
  dspm_pkg::dspm_fn_t idx_fn_reg,  idx_fn_next;
  dspm_pkg::dspm_fn_t home_fn_reg, home_fn_next;
  logic               strap_done_reg, strap_done_next;

  // Map a requested selection onto a pin function
  function automatic dspm_pkg::dspm_fn_t fn_decode(input logic alt, input logic [1:0] sel);
    dspm_pkg::dspm_fn_t f;
    f = dspm_pkg::DSPM_FN_DEC;
    if (alt)
      f = dspm_pkg::DSPM_FN_SPI;
    else if (sel == dspm_pkg::FSEL_TIMER)
      f = dspm_pkg::DSPM_FN_TIMER;
    else if (sel == dspm_pkg::FSEL_GPIO)
      f = dspm_pkg::DSPM_FN_GPIO;
    return f;
  endfunction

  // Variant default after release, then software selection
  always_comb
  begin
    idx_fn_next     = idx_fn_reg;
    home_fn_next    = home_fn_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg)
    begin
      idx_fn_next  = i_full_variant ? dspm_pkg::DSPM_FN_DEC : dspm_pkg::DSPM_FN_NONE;
      home_fn_next = i_full_variant ? dspm_pkg::DSPM_FN_DEC : dspm_pkg::DSPM_FN_NONE;
    end
    else if (i_cfg_valid)
    begin
      idx_fn_next  = fn_decode(i_index_alternate_sel, i_idx_fn_sel);
      home_fn_next = fn_decode(i_home_alternate_sel, i_home_fn_sel);
    end
  end

  // Function state registers
  always_ff @(posedge i_clk or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      idx_fn_reg     <= dspm_pkg::DSPM_FN_NONE;
      home_fn_reg    <= dspm_pkg::DSPM_FN_NONE;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      idx_fn_reg     <= idx_fn_next;
      home_fn_reg    <= home_fn_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // ---------------------------------------------------------------
  // Pad drive and peripheral inputs
  // ---------------------------------------------------------------
  logic pad_idx_next, idx_oe_next,  idx_pu_next,   pad_home_next, home_oe_next;
  logic home_pu_next, dec_idx_next, dec_home_next, tb2_next,      tb3_next;
  logic gp2_next,     gp3_next,     ss_next,       mfault_next;

  // Route each pin by its selected function
  always_comb
  begin
    pad_idx_next  = 1'b0;
    idx_oe_next   = 1'b0;
    pad_home_next = 1'b0;
    home_oe_next  = 1'b0;
    idx_pu_next   = i_port_c_pullup_enable_reg[dspm_pkg::PC_BIT_IDX];
    home_pu_next  = i_port_c_pullup_enable_reg[dspm_pkg::PC_BIT_HOME];
    dec_idx_next  = 1'b0;
    dec_home_next = 1'b0;
    tb2_next      = 1'b0;
    tb3_next      = 1'b0;
    gp2_next      = 1'b0;
    gp3_next      = 1'b0;
    ss_next       = 1'b1;
    mfault_next   = 1'b0;
    case (home_fn_reg)
      dspm_pkg::DSPM_FN_DEC:   dec_home_next = pad_sync[1];
      dspm_pkg::DSPM_FN_TIMER:
      begin
        tb3_next     = pad_sync[1];
        pad_home_next = i_tb3_out;
        home_oe_next  = i_tb3_oe;
      end
      dspm_pkg::DSPM_FN_SPI:
      begin
        ss_next     = pad_sync[1];
        mfault_next = i_spi_master & ~pad_sync[1];
      end
      dspm_pkg::DSPM_FN_GPIO:
      begin
        gp3_next      = pad_sync[1];
        pad_home_next = i_port_c_pin3_out;
        home_oe_next  = i_port_c_pin3_dir;
      end
      default: ss_next = 1'b1;
    endcase
    case (idx_fn_reg)
      dspm_pkg::DSPM_FN_DEC:   dec_idx_next = pad_sync[0];
      dspm_pkg::DSPM_FN_TIMER:
      begin
        tb2_next     = pad_sync[0];
        pad_idx_next = i_tb2_out;
        idx_oe_next  = i_tb2_oe;
      end
      dspm_pkg::DSPM_FN_SPI:
      begin
        // Slave drives only while selected; data timing set by SPI unit
        pad_idx_next = i_spi_slave_out_line;
        idx_oe_next  = ~i_spi_master & ~ss_next;
      end
      dspm_pkg::DSPM_FN_GPIO:
      begin
        gp2_next     = pad_sync[0];
        pad_idx_next = i_port_c_pin2_out;
        idx_oe_next  = i_port_c_pin2_dir;
      end
      default: idx_oe_next = 1'b0;
    endcase
  end

  // Output registers drive the ports directly; reset leaves pins as pulled-up inputs
  always_ff @(posedge i_clk or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      o_pad_idx             <= 1'b0;
      o_pad_idx_oe          <= 1'b0;
      o_pad_idx_pu          <= 1'b1;
      o_pad_home            <= 1'b0;
      o_pad_home_oe         <= 1'b0;
      o_pad_home_pu         <= 1'b1;
      o_decoder_index_in    <= 1'b0;
      o_decoder_home_in     <= 1'b0;
      o_timer_b_ch2_io      <= 1'b0;
      o_timer_b_ch3_io      <= 1'b0;
      o_port_c_pin2         <= 1'b0;
      o_port_c_pin3         <= 1'b0;
      o_spi_slave_select_in <= 1'b1;
      o_spi_mode_fault      <= 1'b0;
    end
    else
    begin
      o_pad_idx             <= pad_idx_next;
      o_pad_idx_oe          <= idx_oe_next;
      o_pad_idx_pu          <= idx_pu_next;
      o_pad_home            <= pad_home_next;
      o_pad_home_oe         <= home_oe_next;
      o_pad_home_pu         <= home_pu_next;
      o_decoder_index_in    <= dec_idx_next;
      o_decoder_home_in     <= dec_home_next;
      o_timer_b_ch2_io      <= tb2_next;
      o_timer_b_ch3_io      <= tb3_next;
      o_port_c_pin2         <= gp2_next;
      o_port_c_pin3         <= gp3_next;
      o_spi_slave_select_in <= ss_next;
      o_spi_mode_fault      <= mfault_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!rstn_reg);

  property p_spi_tristate;
    (idx_fn_reg == dspm_pkg::DSPM_FN_SPI && pad_sync[1]) |=> !o_pad_idx_oe;
  endproperty
  a_spi_tristate: assert property (p_spi_tristate) else $error("slave output driven while unselected");
  property p_spi_drive;
    (idx_fn_reg == dspm_pkg::DSPM_FN_SPI && !i_spi_master && !pad_sync[1] && home_fn_reg == dspm_pkg::DSPM_FN_SPI)
      |=> (o_pad_idx_oe && o_pad_idx == $past(i_spi_slave_out_line));
  endproperty
  a_spi_drive: assert property (p_spi_drive) else $error("selected slave not driving");
  property p_idx_alt;
    (strap_done_reg && i_cfg_valid && i_index_alternate_sel) |=> (idx_fn_reg == dspm_pkg::DSPM_FN_SPI);
  endproperty
  a_idx_alt: assert property (p_idx_alt) else $error("index pin not moved to SPI");
  property p_home_alternate_sel;
    (home_fn_reg != dspm_pkg::DSPM_FN_SPI) |=> o_spi_slave_select_in;
  endproperty
  a_home_alternate_sel: assert property (p_home_alternate_sel) else $error("select active without SPI routing");
  property p_dec_route;
    (idx_fn_reg == dspm_pkg::DSPM_FN_DEC) |=> (o_decoder_index_in == $past(pad_sync[0]) && !o_pad_idx_oe);
  endproperty
  a_dec_route: assert property (p_dec_route) else $error("index input not routed");
  property p_gpio_dir;
    (home_fn_reg == dspm_pkg::DSPM_FN_GPIO) |=> (o_pad_home_oe == $past(i_port_c_pin3_dir));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("GPIO direction not followed");
  sequence s_release;
    !strap_done_reg ##1 strap_done_reg;
  endsequence
  property p_variant;
    s_release |-> (idx_fn_reg == (i_full_variant ? dspm_pkg::DSPM_FN_DEC : dspm_pkg::DSPM_FN_NONE));
  endproperty
  a_variant: assert property (p_variant) else $error("wrong reset default function");
  property p_pullup;
    1'b1 |=> (o_pad_idx_pu == $past(i_port_c_pullup_enable_reg[dspm_pkg::PC_BIT_IDX])
              && o_pad_home_pu == $past(i_port_c_pullup_enable_reg[dspm_pkg::PC_BIT_HOME]));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up does not follow enable bit");
  property p_mfault;
    (home_fn_reg == dspm_pkg::DSPM_FN_SPI && i_spi_master && !pad_sync[1]) |=> o_spi_mode_fault;
  endproperty
  a_mfault: assert property (p_mfault) else $error("master arbitration fault missed");

endmodule

// file: testbench/dspm_pad_peer.sv
// Far side of the two shared pins: an encoder sensor and an SPI master.
// Assumes the mux pad outputs; the bench chooses what the far side drives.
`timescale 1ns/1ps
module dspm_pad_peer
(
  // Clock
  input  wire logic i_clk,
  // Mux pad side
  input  wire logic i_pad_idx,
  input  wire logic i_pad_idx_oe,
  input  wire logic i_pad_idx_pu,
  input  wire logic i_pad_home,
  input  wire logic i_pad_home_oe,
  input  wire logic i_pad_home_pu,
  // Far side drive
  input  wire logic i_idx_drv,
  input  wire logic i_idx_val,
  input  wire logic i_home_drv,
  input  wire logic i_home_val,
  // Resolved wires
  output logic      o_idx_wire,
  output logic      o_home_wire
);
  logic flt_reg = 1'b0;

  // Undriven pin without pull-up wanders each cycle
  always @(posedge i_clk)
    flt_reg <= ~flt_reg;

  // Wire level from all parties; master drives select to address us
  always_comb
  begin
    o_idx_wire  = i_pad_idx_oe ? i_pad_idx : i_idx_drv ? i_idx_val : i_pad_idx_pu ? 1'b1 : flt_reg;
    o_home_wire = i_pad_home_oe ? i_pad_home : i_home_drv ? i_home_val : i_pad_home_pu ? 1'b1 : ~flt_reg;
  end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the decoder/SPI shared pin multiplexer.
// Assumes the pad peer model resolves both pad wires.
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_full_variant = 1'b1;
  logic i_index_alternate_sel = 1'b0, i_home_alternate_sel = 1'b0, i_cfg_valid = 1'b0;
  logic [1:0] i_idx_fn_sel = 2'h0, i_home_fn_sel = 2'h0;
  logic [15:0] i_port_c_pullup_enable_reg = 16'hFFFF;
  logic i_spi_master = 1'b0, i_spi_slave_out_line = 1'b0;
  logic i_tb2_out = 1'b0, i_tb2_oe = 1'b0, i_tb3_out = 1'b0, i_tb3_oe = 1'b0;
  logic i_port_c_pin2_out = 1'b0, i_port_c_pin2_dir = 1'b0, i_port_c_pin3_out = 1'b0, i_port_c_pin3_dir = 1'b0;
  logic idx_drv = 1'b0, idx_val = 1'b0, home_drv = 1'b0, home_val = 1'b0, idx_wire, home_wire;
  logic sel_in, fault, t2, t3, pc2, pc3, dec_idx, dec_home;
  logic p_idx, p_idx_oe, p_idx_pu, p_home, p_home_oe, p_home_pu;
  int   failures = 0, check_count = 0, cyc = 0;

  // -----------------------------------------------------------------
  // Clock, timeout and instances
  // -----------------------------------------------------------------
  always #4 i_clk = ~i_clk;

  // Cut a hang short
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      end_sim();
    end
  end

  dspm_pin_mux i_dspm_pin_mux (.i_clk(i_clk), .i_rstn(i_rstn), .i_full_variant(i_full_variant),
    .i_index_alternate_sel(i_index_alternate_sel), .i_home_alternate_sel(i_home_alternate_sel),
    .i_idx_fn_sel(i_idx_fn_sel), .i_home_fn_sel(i_home_fn_sel), .i_cfg_valid(i_cfg_valid),
    .i_port_c_pullup_enable_reg(i_port_c_pullup_enable_reg), .i_spi_master(i_spi_master),
    .i_spi_slave_out_line(i_spi_slave_out_line), .o_spi_slave_select_in(sel_in), .o_spi_mode_fault(fault),
    .i_tb2_out(i_tb2_out), .i_tb2_oe(i_tb2_oe), .i_tb3_out(i_tb3_out), .i_tb3_oe(i_tb3_oe),
    .o_timer_b_ch2_io(t2), .o_timer_b_ch3_io(t3), .i_port_c_pin2_out(i_port_c_pin2_out),
    .i_port_c_pin2_dir(i_port_c_pin2_dir), .i_port_c_pin3_out(i_port_c_pin3_out),
    .i_port_c_pin3_dir(i_port_c_pin3_dir), .o_port_c_pin2(pc2), .o_port_c_pin3(pc3),
    .o_decoder_index_in(dec_idx), .o_decoder_home_in(dec_home), .i_pad_idx(idx_wire), .i_pad_home(home_wire),
    .o_pad_idx(p_idx), .o_pad_idx_oe(p_idx_oe), .o_pad_idx_pu(p_idx_pu),
    .o_pad_home(p_home), .o_pad_home_oe(p_home_oe), .o_pad_home_pu(p_home_pu));

  dspm_pad_peer i_dspm_pad_peer (.i_clk(i_clk), .i_pad_idx(p_idx), .i_pad_idx_oe(p_idx_oe),
    .i_pad_idx_pu(p_idx_pu), .i_pad_home(p_home), .i_pad_home_oe(p_home_oe), .i_pad_home_pu(p_home_pu),
    .i_idx_drv(idx_drv), .i_idx_val(idx_val), .i_home_drv(home_drv), .i_home_val(home_val),
    .o_idx_wire(idx_wire), .o_home_wire(home_wire));

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Let several edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic ext(input logic id, input logic iv, input logic hd, input logic hv);
    @(posedge i_clk);
    idx_drv  <= id;
    idx_val  <= iv;
    home_drv <= hd;
    home_val <= hv;
    settle(5);
  endtask

  task automatic cfg(input logic [1:0] fi, input logic [1:0] fh, input logic ai, input logic ah);
    @(posedge i_clk);
    i_idx_fn_sel          <= fi;
    i_home_fn_sel         <= fh;
    i_index_alternate_sel <= ai;
    i_home_alternate_sel  <= ah;
    i_cfg_valid           <= 1'b1;
    settle(4);
  endtask

  task automatic do_reset(input logic full);
    @(posedge i_clk);
    i_rstn         <= 1'b0;
    i_cfg_valid    <= 1'b0;
    i_full_variant <= full;
    settle(2);
    chk("idx_oe", 1'b0, p_idx_oe);
    chk("home_oe", 1'b0, p_home_oe);
    chk("idx_pu", 1'b1, p_idx_pu);
    chk("home_pu", 1'b1, p_home_pu);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    settle(8);
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_variants();
    do_reset(1'b0);
    ext(1'b1, 1'b1, 1'b1, 1'b1);
    chk("dec_idx", 1'b0, dec_idx);
    chk("dec_home", 1'b0, dec_home);
    do_reset(1'b1);
    chk("dec_idx", 1'b1, dec_idx);
    chk("dec_home", 1'b1, dec_home);
    ext(1'b1, 1'b0, 1'b1, 1'b0);
    chk("dec_idx", 1'b0, dec_idx);
    chk("dec_home", 1'b0, dec_home);
  endtask

  task automatic t_timer();
    i_tb2_oe  <= 1'b1;
    i_tb2_out <= 1'b1;
    cfg(2'h1, 2'h1, 1'b0, 1'b0);
    ext(1'b0, 1'b0, 1'b1, 1'b1);
    chk("idx_oe", 1'b1, p_idx_oe);
    chk("idx_pad", 1'b1, p_idx);
    chk("home_oe", 1'b0, p_home_oe);
    chk("tb3", 1'b1, t3);
    chk("dec_home", 1'b0, dec_home);
    i_tb2_out <= 1'b0;
    settle(3);
    chk("idx_pad", 1'b0, p_idx);
    i_tb2_oe <= 1'b0;
    ext(1'b1, 1'b1, 1'b1, 1'b0);
    chk("tb2", 1'b1, t2);
    chk("idx_oe", 1'b0, p_idx_oe);
  endtask

  task automatic t_gpio();
    i_port_c_pin2_dir <= 1'b1;
    cfg(2'h2, 2'h2, 1'b0, 1'b0);
    ext(1'b0, 1'b0, 1'b1, 1'b1);
    chk("idx_oe", 1'b1, p_idx_oe);
    chk("idx_pad", 1'b0, p_idx);
    chk("pc3", 1'b1, pc3);
    i_port_c_pin2_dir <= 1'b0;
    i_port_c_pin3_dir <= 1'b1;
    ext(1'b1, 1'b1, 1'b0, 1'b0);
    chk("home_oe", 1'b1, p_home_oe);
    chk("home_pad", 1'b0, p_home);
    chk("pc2", 1'b1, pc2);
    i_port_c_pin3_dir <= 1'b0;
  endtask

  task automatic t_spi();
    i_spi_slave_out_line <= 1'b1;
    cfg(2'h0, 2'h0, 1'b1, 1'b1);
    ext(1'b0, 1'b0, 1'b1, 1'b1);
    chk("idx_oe", 1'b0, p_idx_oe);
    chk("sel_in", 1'b1, sel_in);
    ext(1'b0, 1'b0, 1'b1, 1'b0);
    chk("sel_in", 1'b0, sel_in);
    chk("idx_oe", 1'b1, p_idx_oe);
    chk("idx_pad", 1'b1, p_idx);
    i_spi_slave_out_line <= 1'b0;
    settle(3);
    chk("idx_pad", 1'b0, p_idx);
    i_spi_master <= 1'b1;
    settle(4);
    chk("fault", 1'b1, fault);
    chk("idx_oe", 1'b0, p_idx_oe);
    ext(1'b0, 1'b0, 1'b1, 1'b1);
    chk("fault", 1'b0, fault);
    i_spi_master <= 1'b0;
    cfg(2'h3, 2'h3, 1'b0, 1'b0);
    chk("dec_idx", 1'b1, dec_idx);
    chk("idx_oe", 1'b0, p_idx_oe);
    chk("sel_in", 1'b1, sel_in);
  endtask

  task automatic t_pullup();
    i_port_c_pullup_enable_reg <= 16'hFFFB;
    settle(3);
    chk("idx_pu", 1'b0, p_idx_pu);
    chk("home_pu", 1'b1, p_home_pu);
    i_port_c_pullup_enable_reg <= 16'hFFF7;
    settle(3);
    chk("idx_pu", 1'b1, p_idx_pu);
    chk("home_pu", 1'b0, p_home_pu);
    i_port_c_pullup_enable_reg <= 16'hFFFF;
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    t_variants();
    t_timer();
    t_gpio();
    t_spi();
    t_pullup();
    end_sim();
  end
endmodule
